//--- manchester_remote_receiver_test.sv
`timescale 1ns/10ps
`include "mrr_consts.svh"
// ****************************************
// Receiver testbench
// ****************************************
module manchester_remote_receiver_test;
	logic clk_in;
	logic rst_n_in;
	logic ir_line;
	logic [3:0] addr_in;
	logic [7:0] wr_data_in;
	logic wr_en_in;
	logic rd_en_in;
	logic [7:0] rd_data_out;
	logic guide_ok_out;
	logic shift_full_out;
	logic data_error_out;
	logic rx_end_out;
	logic rx_hold_out;
	int err_count = 0;
	int num_checks = 0;

	mrr_receiver uut (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.ir_line_in(ir_line),
		.addr_in(addr_in),
		.wr_data_in(wr_data_in),
		.wr_en_in(wr_en_in),
		.rd_en_in(rd_en_in),
		.rd_data_out(rd_data_out),
		.guide_ok_out(guide_ok_out),
		.shift_full_out(shift_full_out),
		.data_error_out(data_error_out),
		.rx_end_out(rx_end_out),
		.rx_hold_out(rx_hold_out)
	);

	mrr_remote_model #(.HALF(15)) remote (
		.clk_in(clk_in),
		.ir_out(ir_line)
	);

	// ****************************************
	// Bus cycles and comparisons
	// ****************************************
	always #25 clk_in = ~clk_in;

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			$display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
			err_count++;
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_in);
		wr_en_in <= 1'b1;
		addr_in <= a;
		wr_data_in <= d;
		@(posedge clk_in);
		wr_en_in <= 1'b0;
	endtask : wr

	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_in);
		rd_en_in <= 1'b1;
		addr_in <= a;
		@(posedge clk_in);
		rd_en_in <= 1'b0;
		@(posedge clk_in);
		d = rd_data_out;
	endtask : rd

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string msg);
		logic [7:0] v;
		rd(a, v);
		chk(v, exp, msg);
	endtask : rd_chk

	// Status register and flag ports must agree
	task automatic chk_stat(input logic [7:0] exp, input string msg);
		rd_chk(`MRR_ADDR_STAT, exp, msg);
		chk({3'h0, rx_hold_out, rx_end_out, data_error_out, shift_full_out, guide_ok_out},
			exp, msg);
	endtask : chk_stat

	// Bounded wait for the halt after end of reception
	task automatic wait_hold();
		int n;
		n = 0;
		while (rx_hold_out !== 1'b1 && n < 200) begin
			@(posedge clk_in);
			n++;
		end
		chk({7'h00, rx_hold_out}, 8'h01, "receiver halted at end");
	endtask : wait_hold

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : report_and_stop

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_regs();
		chk_stat(8'h00, "flags after reset");
		rd_chk(`MRR_ADDR_CTRL, 8'h00, "control after reset");
		wr(`MRR_ADDR_TIM1, 8'h03);
		wr(`MRR_ADDR_TIM2, 8'h07);
		wr(`MRR_ADDR_TIM3, 8'h0B);
		wr(`MRR_ADDR_TIM4, 8'h11);
		wr(`MRR_ADDR_GPL, 8'h07);
		wr(`MRR_ADDR_GPH, 8'h0F);
		wr(`MRR_ADDR_BUF, 8'h5A);
		wr(`MRR_ADDR_GPRE, 8'h02);
		rd_chk(`MRR_ADDR_GPRE, 8'h02, "guide prescale field");
		wr(`MRR_ADDR_GPRE, 8'h00);
		rd_chk(`MRR_ADDR_BUF, 8'h00, "buffer is read only");
		rd_chk(4'hF, 8'h00, "unmapped read");
		// Nonzero read last, so a lingering value would show
		rd_chk(`MRR_ADDR_TIM4, 8'h11, "timing 4 field");
		@(posedge clk_in);
		chk(rd_data_out, 8'h00, "read data stands one cycle");
		$display("test regs done");
	endtask : test_regs

	task automatic test_d_lsb();
		wr(`MRR_ADDR_CTRL, 8'h09);
		remote.send(1'b0, 16'h00B5, 8, 99, 0);
		wait_hold();
		chk_stat(8'h1A, "format D end flags");
		rd_chk(`MRR_ADDR_BUF, 8'hB5, "format D byte");
		rd_chk(`MRR_ADDR_BCNT, 8'h08, "format D bit count");
		rd_chk(`MRR_ADDR_SHIFT, 8'h00, "shift cleared after byte");
		chk_stat(8'h0A, "shift read releases hold");
		wr(`MRR_ADDR_STAT, 8'h0F);
		$display("test d_lsb done");
	endtask : test_d_lsb

	task automatic test_d_msb();
		logic [15:0] bits;
		logic [7:0] exp;
		bits = 16'h06A3;
		for (int i = 0; i < 8; i++) begin
			exp[7 - i] = bits[i];
		end
		wr(`MRR_ADDR_CTRL, 8'h45);
		remote.send(1'b0, bits, 11, 99, 0);
		wait_hold();
		rd_chk(`MRR_ADDR_BUF, exp, "MSB first byte");
		rd_chk(`MRR_ADDR_BCNT, 8'h0B, "partial byte count");
		rd_chk(`MRR_ADDR_SHIFT, bits[15:8] & 8'h00 | {5'h00, bits[8], bits[9], bits[10]},
			"partial shift MSB first");
		wr(`MRR_ADDR_STAT, 8'h0F);
		$display("test d_msb done");
	endtask : test_d_msb

	task automatic test_tick_rate();
		wr(`MRR_ADDR_CTRL, 8'h01);
		remote.send(1'b0, 16'h0055, 8, 99, 0);
		wait_hold();
		rd_chk(`MRR_ADDR_BCNT, 8'h01, "short tick ends after one bit");
		chk_stat(8'h18, "end without byte");
		rd_chk(`MRR_ADDR_SHIFT, 8'h80, "one bit in shift, LSB first");
		wr(`MRR_ADDR_STAT, 8'h0F);
		$display("test tick_rate done");
	endtask : test_tick_rate

	task automatic test_d_err();
		wr(`MRR_ADDR_CTRL, 8'h09);
		remote.send(1'b0, 16'h0001, 1, 0, 1);
		chk_stat(8'h04, "first bit low is error");
		rd_chk(`MRR_ADDR_BCNT, 8'h00, "count cleared at first rise");
		wr(`MRR_ADDR_STAT, 8'h0F);
		remote.send(1'b0, 16'h0007, 3, 2, 1);
		chk_stat(8'h04, "equal samples are error");
		rd_chk(`MRR_ADDR_BCNT, 8'h02, "bits before error");
		wr(`MRR_ADDR_STAT, 8'h0F);
		$display("test d_err done");
	endtask : test_d_err

	task automatic test_e();
		wr(`MRR_ADDR_CTRL, 8'h0B);
		remote.send(1'b1, 16'h09A6, 12, 99, 0);
		wait_hold();
		chk_stat(8'h1B, "format E end flags");
		rd_chk(`MRR_ADDR_BUF, 8'hA6, "format E byte");
		rd_chk(`MRR_ADDR_BCNT, 8'h0C, "format E bit count");
		rd_chk(`MRR_ADDR_SHIFT, 8'h90, "format E tail bits");
		wr(`MRR_ADDR_STAT, 8'h0F);
		$display("test e done");
	endtask : test_e

	task automatic test_e_err();
		remote.send(1'b1, 16'h0000, 1, 0, 2);
		chk_stat(8'h05, "lead cell without edge");
		wr(`MRR_ADDR_STAT, 8'h0F);
		remote.send(1'b1, 16'h0004, 3, 2, 1);
		chk_stat(8'h05, "format E equal samples");
		rd_chk(`MRR_ADDR_BCNT, 8'h02, "format E bits before error");
		$display("test e_err done");
	endtask : test_e_err

	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial begin
		clk_in = 1'b0;
		rst_n_in = 1'b0;
		addr_in = 4'h0;
		wr_data_in = 8'h00;
		wr_en_in = 1'b0;
		rd_en_in = 1'b0;
		repeat (12) @(posedge clk_in);
		rst_n_in <= 1'b1;
		test_regs();
		test_d_lsb();
		test_d_msb();
		test_tick_rate();
		test_d_err();
		test_e();
		test_e_err();
		report_and_stop();
	end

	initial begin
		repeat (30000) @(posedge clk_in);
		$display("wrong value at %0t: watchdog expired", $time);
		err_count++;
		report_and_stop();
	end
endmodule : manchester_remote_receiver_test

//--- mrr_consts.svh
// Summary of operation
// - Four timing points equal (field plus one) ticks
// - Line sampled at timing 1 and 3
// - Format D first rising edge clears shift, count
// - Format D first bit: high is one, else error
// - Bits shift in; every eight copied, flagged, cleared
// - Format D error sets flag, idles until rise
// - Format D edge in timing 3..4 restarts cell
// - End sets end, hold; shift read releases hold
// - Format E guide window accepted, flag, clear, decode
// - Format E error sets flag, waits for guide
// - Leading cells need edge before timing 3
// - Format E edge in timing 3..4 restarts cell
// - After three cells, valid bit halves tick rate
// - Valid long bit restores full tick rate
// - Remaining bits use ordinary cell until end
// - Tick period is base period times two to the prescale
// - Shift order: zero LSB first, one MSB first
// - Bit counter tells valid bits of whole frame
`ifndef MRR_CONSTS_SVH
`define MRR_CONSTS_SVH

// ****************************************
// Register addresses
// ****************************************
`define MRR_ADDR_CTRL 4'h0
`define MRR_ADDR_GPRE 4'h1
`define MRR_ADDR_TIM1 4'h2
`define MRR_ADDR_TIM2 4'h3
`define MRR_ADDR_TIM3 4'h4
`define MRR_ADDR_TIM4 4'h5
`define MRR_ADDR_GPL 4'h6
`define MRR_ADDR_GPH 4'h7
`define MRR_ADDR_STAT 4'h8
`define MRR_ADDR_SHIFT 4'h9
`define MRR_ADDR_BUF 4'hA
`define MRR_ADDR_BCNT 4'hB

// ****************************************
// Field positions
// ****************************************
`define MRR_CTRL_EN 0
`define MRR_CTRL_FMT_E 1
`define MRR_CTRL_ORDER 2
`define MRR_CTRL_TSEL_LO 3
`define MRR_CTRL_TSEL_HI 5
`define MRR_CTRL_DPRE_LO 6
`define MRR_CTRL_DPRE_HI 7
`define MRR_STAT_GOK 0
`define MRR_STAT_SFULL 1
`define MRR_STAT_DERR 2
`define MRR_STAT_REND 3
`define MRR_STAT_HOLD 4

// ****************************************
// Reset values and constants
// ****************************************
`define MRR_RST_BYTE 8'h00
`define MRR_RST_FIELD 5'h00
`define MRR_RST_SEL2 2'h0
`define MRR_TIM_PLUS 6'h01
`define MRR_BYTE_LAST 3'h7

// ****************************************
// Cell stages along a frame
// ****************************************
`define MRR_STG_LEAD0 4'h0
`define MRR_STG_ORD1 4'h1
`define MRR_STG_DEC4 4'h4
`define MRR_STG_LEAD5 4'h5
`define MRR_STG_DEC6 4'h6
`define MRR_STG_LEAD7 4'h7
`define MRR_STG_ORDN 4'h8
`define MRR_STG_ONE 4'h1

`endif

//--- mrr_pkg.sv
// ****************************************
// Shared types
// ****************************************
package mrr_pkg;
	typedef enum logic [2:0] {
		MRR_IDLE = 3'h0,
		MRR_GUIDE = 3'h1,
		MRR_T1 = 3'h3,
		MRR_T2 = 3'h2,
		MRR_T3 = 3'h6,
		MRR_EDGE = 3'h7,
		MRR_LEAD = 3'h5,
		MRR_HOLD = 3'h4
	} mrr_state_e;
	typedef logic [3:0] mrr_stage_t;
endpackage : mrr_pkg

//--- mrr_receiver.sv
`timescale 1ns/10ps
`include "mrr_consts.svh"
// ****************************************
// Manchester remote receiver, formats D and E
// ****************************************
module mrr_receiver import mrr_pkg::*; #(
	parameter int FIELD_W = 5,
	parameter int CNT_W = 6
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ir_line_in,
	input wire logic [3:0] addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	output logic [7:0] rd_data_out,
	output logic guide_ok_out,
	output logic shift_full_out,
	output logic data_error_out,
	output logic rx_end_out,
	output logic rx_hold_out
);
	if (CNT_W <= FIELD_W || FIELD_W > 8) begin : g_chk
		$error("mrr_receiver: CNT_W must exceed FIELD_W, FIELD_W at most 8");
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	logic en_q, en_d, fmt_e_q, fmt_e_d, order_q, order_d;
	logic [2:0] tsel_q, tsel_d;
	logic [1:0] dpre_q, dpre_d, gpre_q, gpre_d;
	logic [FIELD_W-1:0] t1_q, t1_d, t2_q, t2_d, t3_q, t3_d, t4_q, t4_d;
	logic [FIELD_W-1:0] gpl_q, gpl_d, gph_q, gph_d;
	logic [7:0] rdata_d;

	// Receiver state
	mrr_state_e state_q, state_d;
	mrr_stage_t stage_q, stage_d;
	logic [CNT_W-1:0] pw_q, pw_d;
	logic [7:0] shift_q, shift_d, buf_q, buf_d, bcnt_q, bcnt_d;
	logic first_q, first_d, half_q, half_d, s1_q, s1_d, prev_q, prev_d;
	logic gok_q, gok_d, sfull_q, sfull_d, derr_q, derr_d, rend_q, rend_d, hold_q, hold_d;
	logic line_q, line_prev_q, edge_w, rise_w, tick_w, pw_clr;
	logic [3:0] tick_shift;
	logic [CNT_W-1:0] lim1, lim2, lim3, lim4, lim_gl, lim_gh;
	logic wr_ctrl_w, shift_rd_w, stat_wr_w;
	logic ev_valid, ev_err, ev_guide, ev_end, bit_w;
	logic [7:0] shifted_w;

	assign wr_ctrl_w = wr_en_in && (addr_in == `MRR_ADDR_CTRL);
	assign stat_wr_w = wr_en_in && (addr_in == `MRR_ADDR_STAT);
	assign shift_rd_w = rd_en_in && (addr_in == `MRR_ADDR_SHIFT);

	// Register writes and read data mux
	always_comb begin
		en_d = en_q;
		fmt_e_d = fmt_e_q;
		order_d = order_q;
		tsel_d = tsel_q;
		dpre_d = dpre_q;
		gpre_d = gpre_q;
		t1_d = t1_q;
		t2_d = t2_q;
		t3_d = t3_q;
		t4_d = t4_q;
		gpl_d = gpl_q;
		gph_d = gph_q;
		if (wr_ctrl_w) begin
			en_d = wr_data_in[`MRR_CTRL_EN];
			fmt_e_d = wr_data_in[`MRR_CTRL_FMT_E];
			order_d = wr_data_in[`MRR_CTRL_ORDER];
			tsel_d = wr_data_in[`MRR_CTRL_TSEL_HI:`MRR_CTRL_TSEL_LO];
			dpre_d = wr_data_in[`MRR_CTRL_DPRE_HI:`MRR_CTRL_DPRE_LO];
		end
		if (wr_en_in) begin
			case (addr_in)
				`MRR_ADDR_GPRE: gpre_d = wr_data_in[1:0];
				`MRR_ADDR_TIM1: t1_d = wr_data_in[FIELD_W-1:0];
				`MRR_ADDR_TIM2: t2_d = wr_data_in[FIELD_W-1:0];
				`MRR_ADDR_TIM3: t3_d = wr_data_in[FIELD_W-1:0];
				`MRR_ADDR_TIM4: t4_d = wr_data_in[FIELD_W-1:0];
				`MRR_ADDR_GPL: gpl_d = wr_data_in[FIELD_W-1:0];
				`MRR_ADDR_GPH: gph_d = wr_data_in[FIELD_W-1:0];
				default: ;
			endcase
		end
		rdata_d = `MRR_RST_BYTE;
		if (rd_en_in) begin
			case (addr_in)
				`MRR_ADDR_CTRL: rdata_d = {dpre_q, tsel_q, order_q, fmt_e_q, en_q};
				`MRR_ADDR_GPRE: rdata_d = {6'h00, gpre_q};
				`MRR_ADDR_TIM1: rdata_d = 8'(t1_q);
				`MRR_ADDR_TIM2: rdata_d = 8'(t2_q);
				`MRR_ADDR_TIM3: rdata_d = 8'(t3_q);
				`MRR_ADDR_TIM4: rdata_d = 8'(t4_q);
				`MRR_ADDR_GPL: rdata_d = 8'(gpl_q);
				`MRR_ADDR_GPH: rdata_d = 8'(gph_q);
				`MRR_ADDR_STAT: rdata_d = {3'h0, hold_q, rend_q, derr_q, sfull_q, gok_q};
				`MRR_ADDR_SHIFT: rdata_d = shift_q;
				`MRR_ADDR_BUF: rdata_d = buf_q;
				`MRR_ADDR_BCNT: rdata_d = bcnt_q;
				default: rdata_d = `MRR_RST_BYTE;
			endcase
		end
	end

	// Configuration and read data registers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			en_q <= 1'b0;
			fmt_e_q <= 1'b0;
			order_q <= 1'b0;
			tsel_q <= 3'h0;
			dpre_q <= `MRR_RST_SEL2;
			gpre_q <= `MRR_RST_SEL2;
			t1_q <= `MRR_RST_FIELD;
			t2_q <= `MRR_RST_FIELD;
			t3_q <= `MRR_RST_FIELD;
			t4_q <= `MRR_RST_FIELD;
			gpl_q <= `MRR_RST_FIELD;
			gph_q <= `MRR_RST_FIELD;
			rd_data_out <= `MRR_RST_BYTE;
		end else begin
			en_q <= en_d;
			fmt_e_q <= fmt_e_d;
			order_q <= order_d;
			tsel_q <= tsel_d;
			dpre_q <= dpre_d;
			gpre_q <= gpre_d;
			t1_q <= t1_d;
			t2_q <= t2_d;
			t3_q <= t3_d;
			t4_q <= t4_d;
			gpl_q <= gpl_d;
			gph_q <= gph_d;
			rd_data_out <= rdata_d;
		end
	end

	// ****************************************
	// Line sampling and width tick
	// ****************************************
	assign edge_w = line_q ^ line_prev_q;
	assign rise_w = line_q & ~line_prev_q;

	// Line sample and previous value for edge detection
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			line_q <= 1'b0;
			line_prev_q <= 1'b0;
		end else begin
			line_q <= ir_line_in;
			line_prev_q <= line_q;
		end
	end

	// Guide uses its own prescale; data may run at half rate
	always_comb begin
		if (state_q == MRR_GUIDE) begin
			tick_shift = {1'b0, tsel_q} + {2'b00, gpre_q};
		end else begin
			tick_shift = {1'b0, tsel_q} + {2'b00, dpre_q} + {3'b000, half_q};
		end
	end

	mrr_tick #(.DIV_W(12)) u_tick (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.restart_in(pw_clr),
		.shift_in(tick_shift),
		.tick_out(tick_w)
	);

	// Timing points as tick counts, field plus one
	assign lim1 = CNT_W'(t1_q) + `MRR_TIM_PLUS;
	assign lim2 = CNT_W'(t2_q) + `MRR_TIM_PLUS;
	assign lim3 = CNT_W'(t3_q) + `MRR_TIM_PLUS;
	assign lim4 = CNT_W'(t4_q) + `MRR_TIM_PLUS;
	assign lim_gl = CNT_W'(gpl_q) + `MRR_TIM_PLUS;
	assign lim_gh = CNT_W'(gph_q) + `MRR_TIM_PLUS;

	// Bit value is the timing 1 sample; first format D bit is checked on timing 1 only
	assign bit_w = s1_q;
	assign shifted_w = order_q ? {shift_q[6:0], bit_w} : {bit_w, shift_q[7:1]};

	// ****************************************
	// Receive sequencer
	// ****************************************
	always_comb begin
		state_d = state_q;
		stage_d = stage_q;
		pw_clr = 1'b0;
		shift_d = shift_q;
		buf_d = buf_q;
		bcnt_d = bcnt_q;
		first_d = first_q;
		half_d = half_q;
		s1_d = s1_q;
		prev_d = prev_q;
		ev_valid = 1'b0;
		ev_err = 1'b0;
		ev_guide = 1'b0;
		ev_end = 1'b0;
		case (state_q)
			MRR_IDLE: begin
				half_d = 1'b0;
				if (en_q && rise_w) begin
					pw_clr = 1'b1;
					if (fmt_e_q) begin
						state_d = MRR_GUIDE;
					end else begin
						shift_d = `MRR_RST_BYTE;
						bcnt_d = `MRR_RST_BYTE;
						first_d = 1'b1;
						stage_d = `MRR_STG_ORDN;
						state_d = MRR_T1;
					end
				end
			end
			MRR_GUIDE: begin
				if (rise_w) begin
					pw_clr = 1'b1;
					if (pw_q >= lim_gl && pw_q < lim_gh) begin
						ev_guide = 1'b1;
						shift_d = `MRR_RST_BYTE;
						bcnt_d = `MRR_RST_BYTE;
						first_d = 1'b0;
						stage_d = `MRR_STG_LEAD0;
						state_d = MRR_T1;
					end
				end
			end
			MRR_T1: begin
				if (pw_q >= lim1) begin
					s1_d = line_q;
					if (stage_q == `MRR_STG_LEAD0 || stage_q == `MRR_STG_LEAD5 ||
						stage_q == `MRR_STG_LEAD7) begin
						prev_d = line_q;
						state_d = MRR_LEAD;
					end else begin
						state_d = MRR_T2;
					end
				end
			end
			MRR_T2: begin
				if (pw_q >= lim2) begin
					if (first_q ? s1_q : (s1_q ^ prev_q)) begin
						ev_valid = 1'b1;
						first_d = 1'b0;
						bcnt_d = bcnt_q + 8'h01;
						if (bcnt_q[2:0] == `MRR_BYTE_LAST) begin
							buf_d = shifted_w;
							shift_d = `MRR_RST_BYTE;
						end else begin
							shift_d = shifted_w;
						end
						if (stage_q != `MRR_STG_ORDN) begin
							stage_d = stage_q + `MRR_STG_ONE;
						end
						if (stage_q == `MRR_STG_DEC4) begin
							pw_clr = 1'b1;
							half_d = 1'b1;
							state_d = MRR_T1;
						end else if (stage_q == `MRR_STG_DEC6) begin
							pw_clr = 1'b1;
							half_d = 1'b0;
							state_d = MRR_T1;
						end else begin
							state_d = MRR_T3;
						end
					end else begin
						ev_err = 1'b1;
						state_d = MRR_IDLE;
					end
				end
			end
			MRR_T3: begin
				if (pw_q >= lim3) begin
					prev_d = line_q;
					state_d = MRR_EDGE;
				end
			end
			MRR_EDGE: begin
				if (edge_w) begin
					pw_clr = 1'b1;
					state_d = MRR_T1;
				end else if (pw_q >= lim4) begin
					ev_end = 1'b1;
					state_d = MRR_HOLD;
				end
			end
			MRR_LEAD: begin
				if (edge_w) begin
					pw_clr = 1'b1;
					stage_d = stage_q + `MRR_STG_ONE;
					state_d = MRR_T1;
				end else if (pw_q >= lim3) begin
					ev_err = 1'b1;
					state_d = MRR_IDLE;
				end
			end
			MRR_HOLD: begin
				if (shift_rd_w) begin
					state_d = MRR_IDLE;
				end
			end
			default: state_d = MRR_IDLE;
		endcase
		if (!en_q && state_q != MRR_HOLD) begin
			state_d = MRR_IDLE;
		end
		// Width counter counts ticks, saturating, cleared on restart
		if (pw_clr) begin
			pw_d = '0;
		end else if (tick_w && pw_q != {CNT_W{1'b1}}) begin
			pw_d = pw_q + CNT_W'(1);
		end else begin
			pw_d = pw_q;
		end
		// Hardware set wins over a software clear
		gok_d = ev_guide | (gok_q & ~(stat_wr_w & wr_data_in[`MRR_STAT_GOK]));
		sfull_d = (ev_valid && bcnt_q[2:0] == `MRR_BYTE_LAST) |
			(sfull_q & ~(stat_wr_w & wr_data_in[`MRR_STAT_SFULL]));
		derr_d = ev_err | (derr_q & ~(stat_wr_w & wr_data_in[`MRR_STAT_DERR]));
		rend_d = ev_end | (rend_q & ~(stat_wr_w & wr_data_in[`MRR_STAT_REND]));
		hold_d = ev_end | (hold_q & ~(state_q == MRR_HOLD && shift_rd_w));
	end

	// Sequencer registers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_q <= MRR_IDLE;
			stage_q <= `MRR_STG_ORDN;
			pw_q <= '0;
			shift_q <= `MRR_RST_BYTE;
			buf_q <= `MRR_RST_BYTE;
			bcnt_q <= `MRR_RST_BYTE;
			first_q <= 1'b0;
			half_q <= 1'b0;
			s1_q <= 1'b0;
			prev_q <= 1'b0;
			gok_q <= 1'b0;
			sfull_q <= 1'b0;
			derr_q <= 1'b0;
			rend_q <= 1'b0;
			hold_q <= 1'b0;
		end else begin
			state_q <= state_d;
			stage_q <= stage_d;
			pw_q <= pw_d;
			shift_q <= shift_d;
			buf_q <= buf_d;
			bcnt_q <= bcnt_d;
			first_q <= first_d;
			half_q <= half_d;
			s1_q <= s1_d;
			prev_q <= prev_d;
			gok_q <= gok_d;
			sfull_q <= sfull_d;
			derr_q <= derr_d;
			rend_q <= rend_d;
			hold_q <= hold_d;
		end
	end

	// Flag outputs straight from their flops
	assign guide_ok_out = gok_q;
	assign shift_full_out = sfull_q;
	assign data_error_out = derr_q;
	assign rx_end_out = rend_q;
	assign rx_hold_out = hold_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	rise_clear_a: assert property (state_q == MRR_IDLE && en_q && !fmt_e_q && rise_w
		|=> shift_q == `MRR_RST_BYTE && bcnt_q == `MRR_RST_BYTE && state_q == MRR_T1)
		else $error("format D start did not clear shift and count");
	first_bit_a: assert property (state_q == MRR_T2 && first_q && pw_q >= lim2 && !s1_q
		|=> derr_q && state_q == MRR_IDLE)
		else $error("first bit low not flagged as error");
	byte_move_a: assert property (ev_valid && bcnt_q[2:0] == `MRR_BYTE_LAST
		|=> sfull_q && shift_q == `MRR_RST_BYTE && buf_q == $past(shifted_w))
		else $error("full byte not moved to buffer");
	edge_restart_a: assert property (state_q == MRR_EDGE && edge_w && en_q
		|=> state_q == MRR_T1 && pw_q == '0)
		else $error("edge in end window did not restart cell");
	end_hold_a: assert property (ev_end |=> rend_q && hold_q && state_q == MRR_HOLD ##1
		(state_q == MRR_HOLD || !hold_q))
		else $error("end of reception not held");
	hold_release_a: assert property (state_q == MRR_HOLD && shift_rd_w
		|=> state_q == MRR_IDLE && !hold_q)
		else $error("shift read did not release hold");
	guide_accept_a: assert property (ev_guide
		|=> gok_q && pw_q == '0 && bcnt_q == `MRR_RST_BYTE && stage_q == `MRR_STG_LEAD0)
		else $error("guide accept did not start decoding");
	lead_error_a: assert property (state_q == MRR_LEAD && !edge_w && pw_q >= lim3
		|=> derr_q && state_q == MRR_IDLE)
		else $error("missing lead edge not flagged");
	half_rate_a: assert property (ev_valid && stage_q == `MRR_STG_DEC4
		|=> half_q && stage_q == `MRR_STG_LEAD5)
		else $error("tick not halved for long cell");
	full_rate_a: assert property (ev_valid && stage_q == `MRR_STG_DEC6
		|=> !half_q && stage_q == `MRR_STG_LEAD7)
		else $error("tick not restored after long cell");
	equal_err_a: assert property (state_q == MRR_T2 && !first_q && pw_q >= lim2 &&
		s1_q == prev_q |=> derr_q && state_q == MRR_IDLE)
		else $error("equal samples not flagged");

	guide_seen_c: cover property (ev_guide ##[1:1000] ev_valid);
	byte_done_c: cover property (ev_valid && bcnt_q[2:0] == `MRR_BYTE_LAST);
	end_seen_c: cover property (ev_end ##[1:50] shift_rd_w);
	half_seen_c: cover property (half_q ##1 !half_q);
endmodule : mrr_receiver

//--- mrr_remote_model.sv
`timescale 1ns/10ps
// ****************************************
// Remote transmitter seen through the demodulator
// ****************************************
module mrr_remote_model #(
	parameter int HALF = 15
) (
	input wire logic clk_in,
	output logic ir_out
);
	// Demodulated line rests low between frames
	initial begin
		ir_out = 1'b0;
	end

	// Hold the line at one level for a number of clocks
	task automatic hold_line(input logic lvl, input int n);
		ir_out <= lvl;
		repeat (n) @(posedge clk_in);
	endtask : hold_line

	// One frame: optional guide, Manchester bits, then idle low
	// Bad kind 1 turns the mid-cell edge into a short spike, 2 leaves it out
	task automatic send(input logic fmt_e, input logic [15:0] bits, input int n,
		input int bad_bit, input int bad_kind);
		int len;
		@(posedge clk_in);
		if (fmt_e) begin
			hold_line(1'b1, 12); // Guide spans 24 clocks rise to rise
			hold_line(1'b0, 12);
		end
		for (int i = 0; i < n; i++) begin
			len = (fmt_e && i == 4) ? 2 * HALF : HALF; // Trailer bit twice as wide
			hold_line(!bits[i], len);
			if (i == bad_bit && bad_kind == 1) begin
				hold_line(bits[i], 3);
				hold_line(!bits[i], len - 3);
			end else if (i == bad_bit) begin
				hold_line(!bits[i], len);
			end else begin
				hold_line(bits[i], len);
			end
		end
		hold_line(1'b0, 4 * HALF); // Silence longer than timing 4
	endtask : send
endmodule : mrr_remote_model

//--- mrr_tick.sv
`timescale 1ns/10ps
// ****************************************
// Width tick divider
// ****************************************
module mrr_tick #(
	parameter int DIV_W = 12
) (
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic restart_in,
	input wire logic [3:0] shift_in,
	output logic tick_out
);
	logic [DIV_W-1:0] div_q, div_d, lim;
	logic tick_d;

	if (DIV_W < 12) begin : g_chk
		$error("mrr_tick: DIV_W too small for largest division");
	end

	// Terminal count is two to the power of the shift, minus one
	always_comb begin
		lim = (DIV_W'(1) << shift_in) - DIV_W'(1);
		div_d = div_q + DIV_W'(1);
		tick_d = 1'b0;
		if (restart_in) begin
			div_d = '0;
		end else if (div_q >= lim) begin
			div_d = '0;
			tick_d = 1'b1;
		end
	end

	// Divider registers
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			div_q <= '0;
			tick_out <= 1'b0;
		end else begin
			div_q <= div_d;
			tick_out <= tick_d;
		end
	end
endmodule : mrr_tick
